/* hdl/arr_regs.svh */
// Register offsets, key values and constants of the live readout block
`ifndef ARR_REGS_SVH
`define ARR_REGS_SVH

// ==========================================================
// Serial link
`define ARR_DEV_ADDR        7'h2A
`define ARR_BITS_PER_BYTE   4'h8
`define ARR_BIT_ZERO        4'h0
`define ARR_BIT_ONE         4'h1
`define ARR_PTR_STEP        8'h01

// ==========================================================
// Register offsets
`define ARR_OFS_CUR_LOW     8'h19
`define ARR_OFS_CUR_HIGH    8'h1A
`define ARR_OFS_VOLT_LOW    8'h1B
`define ARR_OFS_VOLT_HIGH   8'h1C
`define ARR_OFS_KEY_FIRST   8'h30
`define ARR_OFS_KEY_SECOND  8'h31
`define ARR_OFS_KEY_THIRD   8'h32

// ==========================================================
// Key values
`define ARR_KEY_FIRST       8'h62
`define ARR_KEY_SECOND      8'h86
`define ARR_KEY_EXIT        8'hFF
`define ARR_KEY_THIRD       8'h43

// ==========================================================
// Reset values
`define ARR_RST_BYTE        8'h00
`define ARR_RST_HIGH        3'h0
`define ARR_RST_RSVD        5'h00

`endif

/* hdl/arr_pkg.sv */
// Types shared by the live readout block
package arr_pkg;

    // ==========================================================
    // Serial engine states, Gray along the usual path
    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_ADDR      = 4'h1,
        ST_ADDR_ACK  = 4'h3,
        ST_PTR       = 4'h2,
        ST_PTR_ACK   = 4'h6,
        ST_WDATA     = 4'h7,
        ST_WDATA_ACK = 4'h5,
        ST_RDATA     = 4'h4,
        ST_RDATA_ACK = 4'hC
    } arr_state_t;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [10:0] current;
        logic [10:0] voltage;
    } arr_sample_t;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } arr_wr_t;

    typedef struct packed {
        logic [7:0] first;
        logic [7:0] second;
        logic [7:0] third;
    } arr_key_t;

    // ==========================================================
    // Module state
    typedef struct packed {
        arr_key_t keys;
        logic     firstOk;
        logic     testMode;
        logic     cfgUnlock;
    } arr_lock_t;

    typedef struct packed {
        arr_state_t st;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic       devRead;
        logic       hostAck;
        logic [7:0] ptr;
        logic       sclPrev;
        logic       sdaPrev;
        logic       sdaOe;
        logic       sdaOut;
        logic [7:0] curLow;
        logic [2:0] curHigh;
        logic [4:0] curRsvd;
        logic [7:0] voltLow;
        logic [2:0] voltHigh;
        logic [4:0] voltRsvd;
    } arr_core_t;

endpackage : arr_pkg

/* hdl/arr_unlock.sv */
// Three-key unlock sequencer and key register storage
`timescale 1ns/1ps
`include "arr_regs.svh"

module arr_unlock (
    input  wire logic              clk,       // System clock
    input  wire logic              rst_n,     // Synchronous reset
    input  wire arr_pkg::arr_wr_t  wr,        // Register write strobe
    output arr_pkg::arr_key_t      keys,      // Stored key bytes
    output logic                   testMode,  // Test mode active
    output logic                   cfgUnlock  // Config bits 2:1 writable
);

    arr_pkg::arr_lock_t s;
    arr_pkg::arr_lock_t next_s;

    always_comb begin
        next_s = s;
        if (wr.en) begin
            case (wr.addr)
                `ARR_OFS_KEY_FIRST: begin
                    next_s.keys.first = wr.data;
                    if (wr.data == `ARR_KEY_EXIT) begin
                        next_s.testMode  = 1'b0;
                        next_s.firstOk   = 1'b0;
                        next_s.cfgUnlock = 1'b0;
                    end else if (wr.data == `ARR_KEY_FIRST) begin
                        next_s.firstOk = 1'b1;
                    end else begin
                        next_s.testMode = 1'b0;
                        next_s.firstOk  = 1'b0;
                    end
                end
                `ARR_OFS_KEY_SECOND: begin
                    next_s.keys.second = wr.data;
                    // Out-of-order second key counts as invalid
                    next_s.testMode = s.firstOk && (wr.data == `ARR_KEY_SECOND);
                    next_s.firstOk  = 1'b0;
                end
                `ARR_OFS_KEY_THIRD: begin
                    next_s.keys.third = wr.data;
                    next_s.cfgUnlock  = (wr.data == `ARR_KEY_THIRD);
                end
                default: begin
                    next_s.firstOk = s.firstOk;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s.keys.first  <= `ARR_RST_BYTE;
            s.keys.second <= `ARR_RST_BYTE;
            s.keys.third  <= `ARR_RST_BYTE;
            s.firstOk     <= 1'b0;
            s.testMode    <= 1'b0;
            s.cfgUnlock   <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign keys      = s.keys;
    assign testMode  = s.testMode;
    assign cfgUnlock = s.cfgUnlock;

endmodule : arr_unlock

/* hdl/arr_readout.sv */
// Live converter readout registers and unlock keys behind a two-wire serial slave
// Operation
// - Current upper three bits at 0x1A, clear-on-read
// - Voltage low byte at 0x1B, clear-on-read
// - Voltage upper three bits at 0x1C, clear-on-read
// - Writing 62h to 0x30 arms sequence
// - 86h to 0x31 after first enters
// - Wrong key on either register leaves test
// - FFh to 0x30 leaves all test modes
// - 43h to 0x32 unlocks config bits 2:1
// - Current low byte at 0x19, clear-on-read
`timescale 1ns/1ps
`include "arr_regs.svh"

module arr_readout (
    input  wire logic                 clk,          // System clock, 100 MHz
    input  wire logic                 rst_n,        // Synchronous reset
    input  wire logic                 scl,          // Serial clock from host
    input  wire logic                 sdaIn,        // Serial data level
    output logic                      sdaOut,       // Serial data drive level
    output logic                      sdaOe,        // Serial data drive enable
    input  wire arr_pkg::arr_sample_t sample,       // New converter results
    input  wire logic                 sampleValid,  // Results valid pulse
    output logic                      testMode,     // Test mode active
    output logic                      cfgWritable   // Config bits 2:1 writable
);

    arr_pkg::arr_core_t s;
    arr_pkg::arr_core_t next_s;
    arr_pkg::arr_wr_t   wr;
    arr_pkg::arr_key_t  keys;
    logic               sclRise;
    logic               sclFall;
    logic               startCond;
    logic               stopCond;
    logic               rxState;
    logic               byteDone;
    logic               rdFetch;
    logic [7:0]         rdAddr;
    logic [7:0]         rdData;

    // ==========================================================
    // Register read decode
    function automatic logic [7:0] readReg(input arr_pkg::arr_core_t c,
                                           input arr_pkg::arr_key_t  k,
                                           input logic [7:0]         a);
        case (a)
            `ARR_OFS_CUR_LOW:    readReg = c.curLow;
            `ARR_OFS_CUR_HIGH:   readReg = {c.curRsvd, c.curHigh};
            `ARR_OFS_VOLT_LOW:   readReg = c.voltLow;
            `ARR_OFS_VOLT_HIGH:  readReg = {c.voltRsvd, c.voltHigh};
            `ARR_OFS_KEY_FIRST:  readReg = k.first;
            `ARR_OFS_KEY_SECOND: readReg = k.second;
            `ARR_OFS_KEY_THIRD:  readReg = k.third;
            default:             readReg = `ARR_RST_BYTE;
        endcase
    endfunction : readReg

    // ==========================================================
    // Serial engine and register bank
    always_comb begin
        next_s         = s;
        wr             = '0;
        rdFetch        = 1'b0;
        rdAddr         = s.ptr;
        rdData         = readReg(s, keys, s.ptr);
        next_s.sclPrev = scl;
        next_s.sdaPrev = sdaIn;
        sclRise   = scl & ~s.sclPrev;
        sclFall   = ~scl & s.sclPrev;
        startCond = scl & s.sclPrev & s.sdaPrev & ~sdaIn;
        stopCond  = scl & s.sclPrev & ~s.sdaPrev & sdaIn;
        rxState   = (s.st == arr_pkg::ST_ADDR) || (s.st == arr_pkg::ST_PTR) ||
                    (s.st == arr_pkg::ST_WDATA);
        byteDone  = sclFall && (s.bitCnt == `ARR_BITS_PER_BYTE);

        if (rxState && sclRise && (s.bitCnt != `ARR_BITS_PER_BYTE)) begin
            next_s.shift  = {s.shift[6:0], sdaIn};
            next_s.bitCnt = s.bitCnt + `ARR_BIT_ONE;
        end

        if (startCond) begin
            next_s.st     = arr_pkg::ST_ADDR;
            next_s.bitCnt = `ARR_BIT_ZERO;
            next_s.sdaOe  = 1'b0;
        end else if (stopCond) begin
            next_s.st    = arr_pkg::ST_IDLE;
            next_s.sdaOe = 1'b0;
        end else begin
            case (s.st)
                arr_pkg::ST_ADDR: begin
                    if (byteDone) begin
                        next_s.bitCnt = `ARR_BIT_ZERO;
                        // Foreign address: stay off the bus until next start
                        if (s.shift[7:1] == `ARR_DEV_ADDR) begin
                            next_s.st      = arr_pkg::ST_ADDR_ACK;
                            next_s.sdaOe   = 1'b1;
                            next_s.devRead = s.shift[0];
                        end else begin
                            next_s.st = arr_pkg::ST_IDLE;
                        end
                    end
                end
                arr_pkg::ST_ADDR_ACK: begin
                    if (sclFall) begin
                        if (s.devRead) begin
                            rdFetch       = 1'b1;
                            next_s.shift  = rdData;
                            next_s.sdaOe  = ~rdData[7];
                            next_s.bitCnt = `ARR_BIT_ONE;
                            next_s.ptr    = s.ptr + `ARR_PTR_STEP;
                            next_s.st     = arr_pkg::ST_RDATA;
                        end else begin
                            next_s.sdaOe = 1'b0;
                            next_s.st    = arr_pkg::ST_PTR;
                        end
                    end
                end
                arr_pkg::ST_PTR: begin
                    if (byteDone) begin
                        next_s.bitCnt = `ARR_BIT_ZERO;
                        next_s.ptr    = s.shift;
                        next_s.sdaOe  = 1'b1;
                        next_s.st     = arr_pkg::ST_PTR_ACK;
                    end
                end
                arr_pkg::ST_WDATA: begin
                    if (byteDone) begin
                        next_s.bitCnt = `ARR_BIT_ZERO;
                        wr.en         = 1'b1;
                        wr.addr       = s.ptr;
                        wr.data       = s.shift;
                        next_s.ptr    = s.ptr + `ARR_PTR_STEP;
                        next_s.sdaOe  = 1'b1;
                        next_s.st     = arr_pkg::ST_WDATA_ACK;
                    end
                end
                arr_pkg::ST_PTR_ACK, arr_pkg::ST_WDATA_ACK: begin
                    if (sclFall) begin
                        next_s.sdaOe = 1'b0;
                        next_s.st    = arr_pkg::ST_WDATA;
                    end
                end
                arr_pkg::ST_RDATA: begin
                    if (sclFall) begin
                        if (s.bitCnt == `ARR_BITS_PER_BYTE) begin
                            next_s.sdaOe  = 1'b0;
                            next_s.bitCnt = `ARR_BIT_ZERO;
                            next_s.st     = arr_pkg::ST_RDATA_ACK;
                        end else begin
                            next_s.sdaOe  = ~s.shift[6];
                            next_s.shift  = {s.shift[6:0], 1'b0};
                            next_s.bitCnt = s.bitCnt + `ARR_BIT_ONE;
                        end
                    end
                end
                arr_pkg::ST_RDATA_ACK: begin
                    if (sclRise) begin
                        next_s.hostAck = ~sdaIn;
                    end
                    if (sclFall) begin
                        if (s.hostAck) begin
                            rdFetch       = 1'b1;
                            next_s.shift  = rdData;
                            next_s.sdaOe  = ~rdData[7];
                            next_s.bitCnt = `ARR_BIT_ONE;
                            next_s.ptr    = s.ptr + `ARR_PTR_STEP;
                            next_s.st     = arr_pkg::ST_RDATA;
                        end else begin
                            next_s.st = arr_pkg::ST_IDLE;
                        end
                    end
                end
                arr_pkg::ST_IDLE: begin
                    next_s.sdaOe = 1'b0;
                end
                default: begin
                    next_s.st    = arr_pkg::ST_IDLE;
                    next_s.sdaOe = 1'b0;
                end
            endcase
        end

        // Reserved upper bits are plain storage
        if (wr.en && (wr.addr == `ARR_OFS_CUR_HIGH)) begin
            next_s.curRsvd = wr.data[7:3];
        end
        if (wr.en && (wr.addr == `ARR_OFS_VOLT_HIGH)) begin
            next_s.voltRsvd = wr.data[7:3];
        end

        // Clear only the field that was shifted out
        if (rdFetch) begin
            case (rdAddr)
                `ARR_OFS_CUR_LOW:   next_s.curLow   = `ARR_RST_BYTE;
                `ARR_OFS_CUR_HIGH:  next_s.curHigh  = `ARR_RST_HIGH;
                `ARR_OFS_VOLT_LOW:  next_s.voltLow  = `ARR_RST_BYTE;
                `ARR_OFS_VOLT_HIGH: next_s.voltHigh = `ARR_RST_HIGH;
                default:            next_s.curLow   = next_s.curLow;
            endcase
        end

        // A fresh result beats a clear in the same cycle so no sample is lost
        if (sampleValid) begin
            next_s.curLow   = sample.current[7:0];
            next_s.curHigh  = sample.current[10:8];
            next_s.voltLow  = sample.voltage[7:0];
            next_s.voltHigh = sample.voltage[10:8];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s.st       <= arr_pkg::ST_IDLE;
            s.bitCnt   <= `ARR_BIT_ZERO;
            s.shift    <= `ARR_RST_BYTE;
            s.devRead  <= 1'b0;
            s.hostAck  <= 1'b0;
            s.ptr      <= `ARR_RST_BYTE;
            s.sclPrev  <= 1'b1;
            s.sdaPrev  <= 1'b1;
            s.sdaOe    <= 1'b0;
            s.sdaOut   <= 1'b0;
            s.curLow   <= `ARR_RST_BYTE;
            s.curHigh  <= `ARR_RST_HIGH;
            s.curRsvd  <= `ARR_RST_RSVD;
            s.voltLow  <= `ARR_RST_BYTE;
            s.voltHigh <= `ARR_RST_HIGH;
            s.voltRsvd <= `ARR_RST_RSVD;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Key sequencer
    arr_unlock arr_unlock_i (
        .clk       (clk),
        .rst_n     (rst_n),
        .wr        (wr),
        .keys      (keys),
        .testMode  (testMode),
        .cfgUnlock (cfgWritable)
    );

    // Open drain: level is always low, only the enable moves
    assign sdaOut = s.sdaOut;
    assign sdaOe  = s.sdaOe;

endmodule : arr_readout

/* tb/arr_readout_checker.sv */
// Checker of the unlock flags against serial writes decoded off the wire
`timescale 1ns/1ps
`include "arr_regs.svh"

module arr_readout_checker (
    input wire logic clk,         // System clock
    input wire logic rst_n,       // Synchronous reset
    input wire logic scl,         // Serial clock
    input wire logic sdaIn,       // Data wire level
    input wire logic testMode,    // Test mode flag
    input wire logic cfgWritable  // Config unlock flag
);
    // ==========================================================
    // Write decoder
    logic       sclQ, sdaQ, wrt, ev, armed, entOk;
    logic [3:0] bc;
    logic [1:0] idx;
    logic [7:0] sh, ptr, evA, evD, nb;
    logic [4:0] since;

    assign nb = {sh[6:0], sdaIn};

    // Event fires on the eighth data bit, ahead of the device's own strobe
    always_ff @(posedge clk) begin
        sclQ <= scl;
        sdaQ <= sdaIn;
        ev   <= 1'b0;
        if (since != 5'h1F) since <= since + 5'h01;
        if (ev) begin
            entOk <= evA == 8'h31 && evD == 8'h86 && armed;
            if (evA == 8'h30) armed <= evD == 8'h62;
            if (evA == 8'h31) armed <= 1'b0;
        end
        if (!rst_n) begin
            bc    <= 4'h0;
            idx   <= 2'h0;
            wrt   <= 1'b0;
            armed <= 1'b0;
            entOk <= 1'b0;
            since <= 5'h1F;
        end else if (scl && sclQ && sdaQ && !sdaIn) begin
            bc  <= 4'h0;
            idx <= 2'h0;
        end else if (scl && !sclQ) begin
            sh <= nb;
            bc <= (bc == 4'h8) ? 4'h0 : bc + 4'h1;
            if (bc == 4'h7) begin
                idx <= (idx == 2'h2) ? idx : idx + 2'h1;
                if (idx == 2'h0) wrt <= nb == {`ARR_DEV_ADDR, 1'b0};
                if (idx == 2'h1) ptr <= nb;
                if (idx == 2'h2 && wrt) begin
                    ev    <= 1'b1;
                    evA   <= ptr;
                    evD   <= nb;
                    ptr   <= ptr + 8'h01;
                    since <= 5'h00;
                end
            end
        end
    end

    // ==========================================================
    // Key sequence
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_enter;
        ev && evA == 8'h31 && evD == 8'h86 && armed |-> ##[1:20] testMode;
    endproperty
    a_enter: assert property (p_enter) else $error("test mode not entered");
    property p_bad2;
        ev && evA == 8'h31 && !(evD == 8'h86 && armed) |-> ##[1:20] !testMode;
    endproperty
    a_bad2: assert property (p_bad2) else $error("bad second key kept mode");
    property p_bad1;
        ev && evA == 8'h30 && evD != 8'h62 |-> ##[1:20] !testMode;
    endproperty
    a_bad1: assert property (p_bad1) else $error("bad first key kept mode");
    property p_exit;
        ev && evA == 8'h30 && evD == 8'hFF |-> ##[1:20] (!testMode && !cfgWritable);
    endproperty
    a_exit: assert property (p_exit) else $error("exit key ignored");
    property p_unlock;
        ev && evA == 8'h32 && evD == 8'h43 |-> ##[1:20] cfgWritable;
    endproperty
    a_unlock: assert property (p_unlock) else $error("config not unlocked");
    property p_relock;
        ev && evA == 8'h32 && evD != 8'h43 |-> ##[1:20] !cfgWritable;
    endproperty
    a_relock: assert property (p_relock) else $error("config not relocked");
    property p_rise;
        $rose(testMode) |-> entOk;
    endproperty
    a_rise: assert property (p_rise) else $error("mode entered without keys");
    property p_quiet;
        !$stable({testMode, cfgWritable}) |-> since < 5'h14;
    endproperty
    a_quiet: assert property (p_quiet) else $error("flag moved without write");
endmodule : arr_readout_checker

bind arr_readout arr_readout_checker arr_readout_checker_i (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaIn), .testMode(testMode),
    .cfgWritable(cfgWritable)
);

/* tb/arr_host_model.sv */
// Serial bus host model driving the clock and an open-drain data wire
`timescale 1ns/1ps
`include "arr_regs.svh"

module arr_host_model (
    input  wire logic clk,     // System clock
    input  wire logic sdaOe,   // Device data drive enable
    input  wire logic sdaOut,  // Device data drive level
    output logic      scl,     // Serial clock to device
    output logic      sdaIn    // Resolved data wire level
);
    logic hostSda;

    // Pull-up: a released wire reads high, either side can only pull low
    assign sdaIn = hostSda & (~sdaOe | sdaOut);

    initial begin
        scl     = 1'b1;
        hostSda = 1'b1;
    end

    // Four clocks a phase, above the three the device needs
    task automatic step(input logic s, input logic c);
        hostSda <= s;
        scl     <= c;
        repeat (4) @(posedge clk);
    endtask : step

    task automatic tick(input logic b, output logic r);
        step(b, 1'b0);
        step(b, 1'b1);
        r = sdaIn;
        step(b, 1'b0);
    endtask : tick

    task automatic start();
        step(1'b1, scl);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        step(1'b0, 1'b0);
    endtask : start

    task automatic stop();
        step(1'b0, 1'b0);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
    endtask : stop

    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) tick(d[i], r);
        tick(1'b1, r);
        ack = ~r;
    endtask : put_byte

    // Last byte of a read is refused, earlier ones acknowledged
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            tick(1'b1, r);
            d[i] = r;
        end
        tick(last, r);
    endtask : get_byte

    task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        put_byte({`ARR_DEV_ADDR, 1'b0}, a0);
        put_byte(p, a1);
        put_byte(d, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask : wr

    task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        put_byte({`ARR_DEV_ADDR, 1'b0}, a0);
        put_byte(p, a1);
        start();
        put_byte({`ARR_DEV_ADDR, 1'b1}, a2);
        get_byte(1'b1, d);
        stop();
        ok = a0 & a1 & a2;
    endtask : rd

    // Two bytes in one transfer, pointer steps on after the first
    task automatic rd_pair(input logic [7:0] p, output logic [15:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        put_byte({`ARR_DEV_ADDR, 1'b0}, a0);
        put_byte(p, a1);
        start();
        put_byte({`ARR_DEV_ADDR, 1'b1}, a2);
        get_byte(1'b0, d[7:0]);
        get_byte(1'b1, d[15:8]);
        stop();
        ok = a0 & a1 & a2;
    endtask : rd_pair
endmodule : arr_host_model

/* tb/arr_readout_tb.sv */
// Self-checking bench of the live readout block
`timescale 1ns/1ps
`include "arr_regs.svh"

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
    $display("Error %0t: got %h expected %h", $time, (a), (b)); end end

module arr_readout_tb;
    logic                 clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 sampleValid = 1'b0;
    logic                 scl, sdaIn, sdaOut, sdaOe, ok, testMode, cfgWritable;
    logic [7:0]           rdat;
    arr_pkg::arr_sample_t sample = '0;
    int                   failures = 0;
    int                   cmp_count = 0;
    int                   cycles = 0;

    always #5 clk = ~clk;

    arr_readout arr_readout_i (
        .clk(clk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .sample(sample), .sampleValid(sampleValid),
        .testMode(testMode), .cfgWritable(cfgWritable)
    );
    arr_host_model arr_host_model_i (
        .clk(clk), .sdaOe(sdaOe), .sdaOut(sdaOut), .scl(scl), .sdaIn(sdaIn)
    );

    // ==========================================================
    // Shared tasks
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        arr_host_model_i.rd(a, rdat, ok);
        `CHK(ok, 1'b1)
        `CHK(rdat, e)
    endtask : rd_chk

    task automatic wr_do(input logic [7:0] a, input logic [7:0] d);
        arr_host_model_i.wr(a, d, ok);
        `CHK(ok, 1'b1)
    endtask : wr_do

    task automatic key(input logic [7:0] a, input logic [7:0] d, input logic tm, input logic cw);
        wr_do(a, d);
        `CHK(testMode, tm)
        `CHK(cfgWritable, cw)
    endtask : key

    task automatic load(input arr_pkg::arr_sample_t v);
        @(posedge clk);
        sample      <= v;
        sampleValid <= 1'b1;
        @(posedge clk);
        sampleValid <= 1'b0;
    endtask : load

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        logic [7:0] adr [8] = '{8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h30, 8'h31, 8'h32, 8'h40};
        foreach (adr[i]) rd_chk(adr[i], 8'h00);
        `CHK(testMode, 1'b0)
        `CHK(cfgWritable, 1'b0)
        $display("t_reset done");
    endtask : t_reset

    // Writes to read-only fields must not disturb the loaded results
    task automatic t_readout();
        logic [7:0]  lo;
        logic [15:0] pair;
        load({11'h5A3, 11'h2C6});
        wr_do(8'h1B, 8'h55);
        wr_do(8'h1A, 8'hFF);
        wr_do(8'h1C, 8'h50);
        rd_chk(8'h19, 8'hA3);
        rd_chk(8'h19, 8'h00);
        rd_chk(8'h1A, 8'hFD);
        rd_chk(8'h1A, 8'hF8);
        rd_chk(8'h1B, 8'hC6);
        rd_chk(8'h1B, 8'h00);
        rd_chk(8'h1C, 8'h52);
        rd_chk(8'h1C, 8'h50);
        load({11'h3E1, 11'h000});
        arr_host_model_i.rd(8'h19, lo, ok);
        arr_host_model_i.rd(8'h1A, rdat, ok);
        `CHK({rdat[2:0], lo}, 11'h3E1)
        load({11'h000, 11'h6B4});
        arr_host_model_i.rd_pair(8'h1B, pair, ok);
        `CHK(ok, 1'b1)
        `CHK({pair[10:8], pair[7:0]}, 11'h6B4)
        `CHK(pair[15:11], 5'h0A)
        rd_chk(8'h1B, 8'h00);
        rd_chk(8'h1C, 8'h50);
        $display("t_readout done");
    endtask : t_readout

    task automatic t_keys();
        key(8'h31, 8'h86, 1'b0, 1'b0);
        key(8'h30, 8'h62, 1'b0, 1'b0);
        key(8'h31, 8'h86, 1'b1, 1'b0);
        key(8'h32, 8'h43, 1'b1, 1'b1);
        key(8'h30, 8'hFF, 1'b0, 1'b0);
        key(8'h30, 8'h62, 1'b0, 1'b0);
        key(8'h31, 8'h86, 1'b1, 1'b0);
        key(8'h30, 8'h11, 1'b0, 1'b0);
        key(8'h31, 8'h86, 1'b0, 1'b0);
        key(8'h30, 8'h62, 1'b0, 1'b0);
        key(8'h31, 8'h86, 1'b1, 1'b0);
        key(8'h31, 8'h00, 1'b0, 1'b0);
        key(8'h32, 8'h43, 1'b0, 1'b1);
        key(8'h32, 8'h42, 1'b0, 1'b0);
        rd_chk(8'h31, 8'h00);
        rd_chk(8'h32, 8'h42);
        $display("t_keys done");
    endtask : t_keys

    // ==========================================================
    // Run control
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            report_and_stop();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_readout();
        t_keys();
        report_and_stop();
    end
endmodule : arr_readout_tb
